// ### logic/flash_program_erase_control.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Setting trigger starts the operation; only hardware clears it, at completion or termination.
// - Operations run only while write enable is one.
// - Improper trigger attempt or termination sets error; normal completion clears it.
// - Erase codes 1111, 1101, 1100 are bulk, general and secure segment erase.
// - Erase codes 0010 page erase, 0000 config byte erase; 0011, 0001 start nothing and set error.
// - Program codes 0011 word, 0001 row, 0000 config byte; others start nothing and set error.
// - Unlisted select codes start no operation.
// - Control bits clear only on power-on reset, not on warm reset.
module flash_program_erase_control #(
	parameter int BULK_CYCLES = flash_ctrl_pkg::BULK_ERASE_CYCLES,
	parameter int SEGMENT_CYCLES = flash_ctrl_pkg::SEGMENT_ERASE_CYCLES,
	parameter int PAGE_CYCLES = flash_ctrl_pkg::PAGE_ERASE_CYCLES,
	parameter int CONFIG_CYCLES = flash_ctrl_pkg::CONFIG_BYTE_CYCLES,
	parameter int WORD_CYCLES = flash_ctrl_pkg::WORD_PROGRAM_CYCLES,
	parameter int ROW_CYCLES = flash_ctrl_pkg::ROW_PROGRAM_CYCLES
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic warm_rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic flash_abort,
	output logic flash_busy,
	output flash_ctrl_pkg::op_kind_type flash_operation
);
	localparam int CW = flash_ctrl_pkg::COUNT_WIDTH;

	flash_ctrl_pkg::top_state_type state;
	flash_ctrl_pkg::top_state_type next_state;
	flash_ctrl_pkg::control_type c;
	flash_ctrl_pkg::op_kind_type start_kind;
	logic start_op;
	logic accept;
	logic [15:0] w;
	logic [CW-1:0] start_length;
	logic timer_busy;
	logic timer_done;
	logic abort_op;
	logic write_attempt;
	logic erase_asked;
	logic [flash_ctrl_pkg::SELECT_WIDTH-1:0] select_asked;

	assign accept = hsel && htrans[1] && hready;
	assign w = hwdata[15:0];
	assign abort_op = flash_abort && state.control.trigger;
	// Check helpers: what a data-phase trigger write asks for
	assign write_attempt = state.data_write && state.data_hit && !state.control.trigger
		&& w[flash_ctrl_pkg::TRIGGER_BIT];
	assign erase_asked = w[flash_ctrl_pkg::ERASE_BIT];
	assign select_asked = w[flash_ctrl_pkg::SELECT_LSB +: flash_ctrl_pkg::SELECT_WIDTH];

	// ************************************************************
	// Register access and sequencing
	// ************************************************************
	always_comb begin
		next_state = state;
		c = state.control;
		start_op = 1'b0;
		start_kind = flash_ctrl_pkg::op_none;
		next_state.ready = 1'b1;
		next_state.resp = 1'b0;
		if (state.data_write && state.data_hit) begin
			// Unused bit positions are simply never copied
			c.error = w[flash_ctrl_pkg::ERROR_BIT];
			if (!state.control.trigger) begin
				// Fields freeze while busy so a running operation cannot change
				c.write_enable = w[flash_ctrl_pkg::WRITE_ENABLE_BIT];
				c.erase = w[flash_ctrl_pkg::ERASE_BIT];
				c.select = w[flash_ctrl_pkg::SELECT_LSB +: flash_ctrl_pkg::SELECT_WIDTH];
				if (w[flash_ctrl_pkg::TRIGGER_BIT]) begin
					start_kind = flash_ctrl_pkg::decode_op(c.erase, c.select);
					if (c.write_enable && start_kind != flash_ctrl_pkg::op_none) begin
						c.trigger = 1'b1;
						start_op = 1'b1;
						next_state.active = start_kind;
					end else begin
						c.error = 1'b1;
					end
				end
			end
		end
		if (timer_done) begin
			c.trigger = 1'b0;
			c.error = 1'b0;
			next_state.active = flash_ctrl_pkg::op_none;
		end
		// Termination is applied last so its error set wins
		if (abort_op) begin
			c.trigger = 1'b0;
			c.error = 1'b1;
			next_state.active = flash_ctrl_pkg::op_none;
		end
		next_state.control = c;
		next_state.data_write = accept && hwrite;
		next_state.data_hit = accept && (haddr[31:2] == flash_ctrl_pkg::CONTROL_OFFSET[31:2]);
		// Read data built from the post-write value covers back-to-back write then read
		if (accept && !hwrite && next_state.data_hit) begin
			next_state.rdata = {16'h0000, flash_ctrl_pkg::readback(c)};
		end else begin
			next_state.rdata = 32'h0000_0000;
		end
		// Warm reset drops only bus phase state, never the control bits
		if (warm_rst) begin
			next_state.data_write = 1'b0;
			next_state.data_hit = 1'b0;
		end
	end

	always_comb begin
		case (start_kind)
			flash_ctrl_pkg::op_bulk_erase: start_length = CW'(BULK_CYCLES);
			flash_ctrl_pkg::op_general_segment_erase: start_length = CW'(SEGMENT_CYCLES);
			flash_ctrl_pkg::op_secure_segment_erase: start_length = CW'(SEGMENT_CYCLES);
			flash_ctrl_pkg::op_page_erase: start_length = CW'(PAGE_CYCLES);
			flash_ctrl_pkg::op_config_erase: start_length = CW'(CONFIG_CYCLES);
			flash_ctrl_pkg::op_word_program: start_length = CW'(WORD_CYCLES);
			flash_ctrl_pkg::op_row_program: start_length = CW'(ROW_CYCLES);
			flash_ctrl_pkg::op_config_program: start_length = CW'(CONFIG_CYCLES);
			default: start_length = CW'(1);
		endcase
	end

	// Only the power-on reset clears the control bits
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= flash_ctrl_pkg::TOP_RESET;
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Self-timed operation
	// ************************************************************
	op_timer #(
		.WIDTH(CW)
	) timer (
		.clock(clock),
		.rst(rst),
		.start(start_op),
		.length(start_length),
		.abort(abort_op),
		.busy(timer_busy),
		.done(timer_done)
	);

	assign hreadyout = state.ready;
	assign hresp = state.resp;
	assign hrdata = state.rdata;
	assign flash_busy = state.control.trigger;
	assign flash_operation = state.active;

	// ************************************************************
	// Checks
	// ************************************************************
	a_trigger_clears_done: assert property (@(posedge clock) disable iff (rst)
		timer_done |=> !state.control.trigger) else $error("trigger not cleared");
	a_trigger_held: assert property (@(posedge clock) disable iff (rst)
		state.control.trigger && !timer_done && !abort_op |=> state.control.trigger)
		else $error("trigger dropped early");
	a_trigger_needs_enable: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) |-> state.control.write_enable && timer_busy)
		else $error("operation started without write enable");
	a_fields_frozen: assert property (@(posedge clock) disable iff (rst)
		state.control.trigger |=> state.control.write_enable == $past(state.control.write_enable)
		&& state.control.erase == $past(state.control.erase)
		&& state.control.select == $past(state.control.select))
		else $error("fields changed while busy");
	a_bad_attempt_flags: assert property (@(posedge clock) disable iff (rst)
		write_attempt && !w[flash_ctrl_pkg::WRITE_ENABLE_BIT]
		|=> state.control.error && !state.control.trigger)
		else $error("improper attempt not flagged");
	a_abort_flags: assert property (@(posedge clock) disable iff (rst)
		abort_op |=> state.control.error && !state.control.trigger
		&& state.active == flash_ctrl_pkg::op_none) else $error("termination not flagged");
	a_done_clears_error: assert property (@(posedge clock) disable iff (rst)
		timer_done && !flash_abort |=> !state.control.error) else $error("error kept");

	// ************************************************************
	// Decode, warm reset and unused bit checks
	// ************************************************************
	a_erase_kind: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) && !state.control.erase |-> state.active inside
		{flash_ctrl_pkg::op_word_program, flash_ctrl_pkg::op_row_program,
		flash_ctrl_pkg::op_config_program}) else $error("program bit gave erase");
	a_bulk_decode: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) && state.control.erase && state.control.select == 4'hf
		|-> state.active == flash_ctrl_pkg::op_bulk_erase) else $error("bad bulk");
	a_general_decode: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) && state.control.erase && state.control.select == 4'hd
		|-> state.active == flash_ctrl_pkg::op_general_segment_erase) else $error("bad general");
	a_secure_decode: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) && state.control.erase && state.control.select == 4'hc
		|-> state.active == flash_ctrl_pkg::op_secure_segment_erase) else $error("bad secure");
	a_page_decode: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) && state.control.erase && state.control.select == 4'h2
		|-> state.active == flash_ctrl_pkg::op_page_erase) else $error("bad page");
	a_config_erase: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) && state.control.erase && state.control.select == 4'h0
		|-> state.active == flash_ctrl_pkg::op_config_erase) else $error("bad config erase");
	a_erase_noop: assert property (@(posedge clock) disable iff (rst)
		write_attempt && erase_asked && select_asked inside {4'h3, 4'h1}
		|=> !state.control.trigger) else $error("erase no-op code started");
	a_row_decode: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) && !state.control.erase && state.control.select == 4'h1
		|-> state.active == flash_ctrl_pkg::op_row_program) else $error("bad row");
	a_word_decode: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) && !state.control.erase && state.control.select == 4'h3
		|-> state.active == flash_ctrl_pkg::op_word_program) else $error("bad word");
	a_config_program: assert property (@(posedge clock) disable iff (rst)
		$rose(state.control.trigger) && !state.control.erase && state.control.select == 4'h0
		|-> state.active == flash_ctrl_pkg::op_config_program) else $error("bad config program");
	a_program_noop: assert property (@(posedge clock) disable iff (rst)
		write_attempt && !erase_asked && select_asked inside {4'hf, 4'hd, 4'hc, 4'h2}
		|=> !state.control.trigger) else $error("program no-op code started");
	a_unlisted_idle: assert property (@(posedge clock) disable iff (rst)
		write_attempt && !(select_asked inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hc, 4'hd, 4'hf})
		|=> !state.control.trigger && state.control.error)
		else $error("operation without a listed code");
	a_warm_keeps: assert property (@(posedge clock) disable iff (rst)
		warm_rst && !state.data_write && !timer_done && !abort_op
		|=> state.control == $past(state.control)) else $error("warm reset hit control");
	a_unused_zero: assert property (@(posedge clock) disable iff (rst)
		(hrdata & 32'hffff_1fb0) == 32'h0000_0000) else $error("unused bits read nonzero");
endmodule : flash_program_erase_control

// ### inc/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
	// ************************************************************
	// Register map and field layout
	// ************************************************************
	localparam logic [31:0] CONTROL_OFFSET = 32'h0000_0000;
	localparam int TRIGGER_BIT = 15;
	localparam int WRITE_ENABLE_BIT = 14;
	localparam int ERROR_BIT = 13;
	localparam int ERASE_BIT = 6;
	localparam int SELECT_LSB = 0;
	localparam int SELECT_WIDTH = 4;
	localparam logic [15:0] CONTROL_MASK = 16'he04f;

	// ************************************************************
	// Operation select codes
	// ************************************************************
	localparam logic [3:0] SEL_BULK = 4'hf;
	localparam logic [3:0] SEL_GENERAL = 4'hd;
	localparam logic [3:0] SEL_SECURE = 4'hc;
	localparam logic [3:0] SEL_WORD = 4'h3;
	localparam logic [3:0] SEL_PAGE = 4'h2;
	localparam logic [3:0] SEL_ROW = 4'h1;
	localparam logic [3:0] SEL_CONFIG = 4'h0;

	// ************************************************************
	// Operation durations in clock cycles
	// ************************************************************
	localparam int COUNT_WIDTH = 12;
	localparam int BULK_ERASE_CYCLES = 256;
	localparam int SEGMENT_ERASE_CYCLES = 128;
	localparam int PAGE_ERASE_CYCLES = 64;
	localparam int CONFIG_BYTE_CYCLES = 8;
	localparam int WORD_PROGRAM_CYCLES = 16;
	localparam int ROW_PROGRAM_CYCLES = 96;

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [3:0] {
		op_none,
		op_bulk_erase,
		op_general_segment_erase,
		op_secure_segment_erase,
		op_page_erase,
		op_config_erase,
		op_word_program,
		op_row_program,
		op_config_program
	} op_kind_type;

	typedef struct packed {
		logic trigger;
		logic write_enable;
		logic error;
		logic erase;
		logic [SELECT_WIDTH-1:0] select;
	} control_type;

	typedef struct packed {
		control_type control;
		op_kind_type active;
		logic data_write;
		logic data_hit;
		logic [31:0] rdata;
		logic ready;
		logic resp;
	} top_state_type;

	typedef struct packed {
		logic [COUNT_WIDTH-1:0] count;
		logic running;
		logic done;
	} timer_state_type;

	localparam control_type CONTROL_RESET = '0;
	localparam top_state_type TOP_RESET = '{
		control: CONTROL_RESET,
		active: op_none,
		data_write: 1'b0,
		data_hit: 1'b0,
		rdata: 32'h0000_0000,
		ready: 1'b1,
		resp: 1'b0
	};
	localparam timer_state_type TIMER_RESET = '0;

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic op_kind_type decode_op(input logic erase, input logic [3:0] select);
		op_kind_type kind;
		kind = op_none;
		if (erase) begin
			case (select)
				SEL_BULK: kind = op_bulk_erase;
				SEL_GENERAL: kind = op_general_segment_erase;
				SEL_SECURE: kind = op_secure_segment_erase;
				SEL_PAGE: kind = op_page_erase;
				SEL_CONFIG: kind = op_config_erase;
				default: kind = op_none;
			endcase
		end else begin
			case (select)
				SEL_WORD: kind = op_word_program;
				SEL_ROW: kind = op_row_program;
				SEL_CONFIG: kind = op_config_program;
				default: kind = op_none;
			endcase
		end
		return kind;
	endfunction : decode_op

	function automatic logic [15:0] readback(input control_type c);
		logic [15:0] value;
		value = 16'h0000;
		value[TRIGGER_BIT] = c.trigger;
		value[WRITE_ENABLE_BIT] = c.write_enable;
		value[ERROR_BIT] = c.error;
		value[ERASE_BIT] = c.erase;
		value[SELECT_LSB +: SELECT_WIDTH] = c.select;
		return value & CONTROL_MASK;
	endfunction : readback
endpackage : flash_ctrl_pkg

// ### logic/op_timer.sv
`timescale 1ns/100ps
module op_timer #(
	parameter int WIDTH = flash_ctrl_pkg::COUNT_WIDTH
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic start,
	input wire logic [WIDTH-1:0] length,
	input wire logic abort,
	output logic busy,
	output logic done
);
	flash_ctrl_pkg::timer_state_type state;
	flash_ctrl_pkg::timer_state_type next_state;

	// ************************************************************
	// Self-timed countdown
	// ************************************************************
	always_comb begin
		next_state = state;
		next_state.done = 1'b0;
		if (abort) begin
			next_state.running = 1'b0;
			next_state.count = '0;
		end else if (start && !state.running) begin
			// A zero length would wrap the count to all ones before finishing, so it runs one cycle
			next_state.running = 1'b1;
			next_state.count = (length == '0) ? WIDTH'(1) : length;
		end else if (state.running) begin
			if (state.count == WIDTH'(1)) begin
				next_state.running = 1'b0;
				next_state.done = 1'b1;
				next_state.count = '0;
			end else begin
				next_state.count = state.count - WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state <= flash_ctrl_pkg::TIMER_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign busy = state.running;
	assign done = state.done;

	a_done_ends_run: assert property (@(posedge clock) disable iff (rst)
		done |-> !busy && $past(busy)) else $error("done without a finished run");
endmodule : op_timer

// ### dv/flash_array_model.sv
`timescale 1ns/100ps
// ****************
// Flash array stand-in
// ****************
// Aborts a running operation only when the bench arms it; otherwise it lets
// every operation run to its own end.
module flash_array_model #(
	parameter int ABORT_DELAY = 8
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic flash_busy,
	input wire flash_ctrl_pkg::op_kind_type flash_operation,
	input wire logic abort_arm,
	output logic flash_abort
);
	int count;
	always_ff @(posedge clock) begin
		if (rst || !flash_busy || flash_operation == flash_ctrl_pkg::op_none) begin
			count <= 0;
			flash_abort <= 1'b0;
		end else begin
			count <= count + 1;
			flash_abort <= abort_arm && (count == ABORT_DELAY);
		end
	end
endmodule : flash_array_model

// ### dv/flash_program_erase_control_tb.sv
`timescale 1ns/100ps
// ****************
// Bench
// ****************
module flash_program_erase_control_tb;
	localparam int BULK = 12;
	localparam int SEG = 10;
	localparam int PAGE = 8;
	localparam int CONF = 4;
	localparam int WORD = 6;
	localparam int ROW = 7;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic warm_rst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic abort_arm = 1'b0;
	logic hreadyout, hresp, flash_busy, flash_abort;
	logic [31:0] hrdata;
	flash_ctrl_pkg::op_kind_type flash_operation;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	always #10 clock = ~clock;
	flash_program_erase_control #(.BULK_CYCLES(BULK), .SEGMENT_CYCLES(SEG),
		.PAGE_CYCLES(PAGE), .CONFIG_CYCLES(CONF), .WORD_CYCLES(WORD), .ROW_CYCLES(ROW)) DUT (
		.clock(clock), .rst(rst), .warm_rst(warm_rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.flash_abort(flash_abort), .flash_busy(flash_busy),
		.flash_operation(flash_operation));
	flash_array_model #(.ABORT_DELAY(8)) model (.clock(clock), .rst(rst),
		.flash_busy(flash_busy), .flash_operation(flash_operation),
		.abort_arm(abort_arm), .flash_abort(flash_abort));
	// Cuts a hang short; the full run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check32
	task automatic check_op(input flash_ctrl_pkg::op_kind_type got,
		input flash_ctrl_pkg::op_kind_type exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check_op
	// Sampled at the falling edge: same value as at the next rising edge, no race
	task automatic wait_ready(output logic [31:0] d);
		@(negedge clock);
		while (hreadyout !== 1'b1) @(negedge clock);
		d = hrdata;
		@(posedge clock);
	endtask : wait_ready
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [31:0] unused;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		wait_ready(unused);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready(rd);
	endtask : bus
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] unused;
		bus(1'b1, a, d, unused);
	endtask : wr
	task automatic rd_check(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] got;
		bus(1'b0, a, 32'h0, got);
		check32({31'h0, hresp}, 32'h0);
		check32(got, exp);
	endtask : rd_check
	function automatic flash_ctrl_pkg::op_kind_type expect_kind(input logic e,
		input logic [3:0] c);
		if (e) begin
			case (c)
				4'hf: return flash_ctrl_pkg::op_bulk_erase;
				4'hd: return flash_ctrl_pkg::op_general_segment_erase;
				4'hc: return flash_ctrl_pkg::op_secure_segment_erase;
				4'h2: return flash_ctrl_pkg::op_page_erase;
				4'h0: return flash_ctrl_pkg::op_config_erase;
				default: return flash_ctrl_pkg::op_none;
			endcase
		end
		case (c)
			4'h3: return flash_ctrl_pkg::op_word_program;
			4'h1: return flash_ctrl_pkg::op_row_program;
			4'h0: return flash_ctrl_pkg::op_config_program;
			default: return flash_ctrl_pkg::op_none;
		endcase
	endfunction : expect_kind
	function automatic int span(input flash_ctrl_pkg::op_kind_type k);
		case (k)
			flash_ctrl_pkg::op_bulk_erase: return BULK;
			flash_ctrl_pkg::op_general_segment_erase: return SEG;
			flash_ctrl_pkg::op_secure_segment_erase: return SEG;
			flash_ctrl_pkg::op_page_erase: return PAGE;
			flash_ctrl_pkg::op_word_program: return WORD;
			flash_ctrl_pkg::op_row_program: return ROW;
			default: return CONF;
		endcase
	endfunction : span
	// Unused bits are written high on purpose
	task automatic run_op(input logic e, input logic [3:0] c);
		flash_ctrl_pkg::op_kind_type k;
		int n;
		logic [31:0] v;
		k = expect_kind(e, c);
		v = {16'h0, 2'h1, 7'h0, e, 2'h0, c};
		wr(32'h0, v | 32'h9fb0);
		@(negedge clock);
		check_op(flash_operation, k);
		check32({31'h0, flash_busy}, {31'h0, k != flash_ctrl_pkg::op_none});
		n = 0;
		while (flash_busy === 1'b1 && n < 100) begin
			n++;
			@(negedge clock);
		end
		check32(n, (k == flash_ctrl_pkg::op_none) ? 0 : span(k) + 1);
		@(posedge clock);
		rd_check(32'h0, (k == flash_ctrl_pkg::op_none) ? v | 32'h2000 : v);
	endtask : run_op
	task automatic t_no_enable();
		wr(32'h0, 32'h8042);
		@(negedge clock);
		check32({31'h0, flash_busy}, 32'h0);
		@(posedge clock);
		rd_check(32'h0, 32'h2042);
	endtask : t_no_enable
	// Software cannot clear the trigger nor restart while busy
	task automatic t_abort();
		int n;
		abort_arm <= 1'b1;
		wr(32'h0, 32'hc04f);
		rd_check(32'h0, 32'hc04f);
		wr(32'h0, 32'h0000);
		wr(32'h0, 32'h8003);
		@(negedge clock);
		check_op(flash_operation, flash_ctrl_pkg::op_bulk_erase);
		n = 0;
		while (flash_abort !== 1'b1 && n < 100) begin
			n++;
			@(negedge clock);
		end
		@(negedge clock);
		check32({31'h0, flash_busy}, 32'h0);
		check_op(flash_operation, flash_ctrl_pkg::op_none);
		abort_arm <= 1'b0;
		@(posedge clock);
		rd_check(32'h0, 32'h604f);
	endtask : t_abort
	task automatic t_resets();
		wr(32'h0, 32'h4043);
		warm_rst <= 1'b1;
		repeat (2) @(posedge clock);
		warm_rst <= 1'b0;
		rd_check(32'h0, 32'h4043);
		wr(32'h4, 32'hffff);
		rd_check(32'h4, 32'h0);
		rd_check(32'h0, 32'h4043);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd_check(32'h0, 32'h0);
	endtask : t_resets
	initial begin
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		rd_check(32'h0, 32'h0);
		for (int i = 0; i < 32; i++) begin
			run_op(i[4], i[3:0]);
		end
		t_no_enable();
		t_abort();
		t_resets();
		stop_test();
	end
endmodule : flash_program_erase_control_tb
